// [dwdog_map.svh]
`ifndef DWDOG_MAP_SVH
`define DWDOG_MAP_SVH
`define DWDOG_IDX_WWCR 16'h50D1
`define DWDOG_IDX_WWWR 16'h50D2
`define DWDOG_IDX_IWKR 16'h50E0
`define DWDOG_IDX_IWPR 16'h50E1
`define DWDOG_IDX_IWRLR 16'h50E2
`define DWDOG_IDX_OPT 16'h50E4
`define DWDOG_IDX_NOPT 16'h50E5
`define DWDOG_IDX_STAT 16'h50E6
`define DWDOG_IDX_MASK 16'h50E7
`define DWDOG_RST_WWCR 8'h7F
`define DWDOG_RST_WWWR 8'h7F
`define DWDOG_RST_IWPR 8'h00
`define DWDOG_RST_IWRLR 8'hFF
`define DWDOG_RST_OPT 8'h00
`define DWDOG_RST_NOPT 8'hFF
`define DWDOG_KEY_ENABLE 8'hCC
`define DWDOG_KEY_REFRESH 8'hAA
`define DWDOG_KEY_ACCESS 8'h55
`define DWDOG_WW_ACT_BIT 7
`define DWDOG_WW_T6_BIT 6
`define DWDOG_OPT_IW_HW_BIT 2
`define DWDOG_OPT_WW_HW_BIT 1
`define DWDOG_WW_TICK_CYC 16'd12288
`define DWDOG_SYS_HZ 100000000
`define DWDOG_LSRC_HZ 128000
`define DWDOG_LSRC_DIV (`DWDOG_SYS_HZ / `DWDOG_LSRC_HZ)
`define DWDOG_IW_PRE_BASE 4
`define DWDOG_PR_MAX 3'd6
`endif

// [dwdog_pkg.sv]
package dwdog_pkg;
  typedef enum logic [1:0] {
    DWDOG_EV_WW_EARLY,
    DWDOG_EV_WW_TIMEOUT,
    DWDOG_EV_IW_TIMEOUT,
    DWDOG_EV_OPT_BAD
  } dwdog_event_t;
  typedef logic [3:0] dwdog_evvec_t;
endpackage

// [dwdog_tick_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface dwdog_tick_if;
  logic tick;
  logic clear;
  modport src (output tick, input clear);
  modport dst (input tick, output clear);
endinterface
`default_nettype wire

// [dwdog_div.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dwdog_map.svh"
module dwdog_div #(
  parameter int unsigned DIV = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  dwdog_tick_if.src tk
);
  logic [15:0] cnt;
  wire logic wrap = (cnt == 16'(DIV - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i || tk.clear || wrap) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || tk.clear) begin
      tk.tick <= 1'b0;
    end else begin
      tk.tick <= wrap;
    end
  end
endmodule
`default_nettype wire

// [dwdog_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dwdog_map.svh"
module dwdog_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [7:0] dat_i,
  input wire logic sel_i,
  output logic [7:0] dat_o,
  output logic ack_o,
  output logic wdog_reset_o,
  output logic irq_o
);
  logic [7:0] ww_ctrl;
  logic [7:0] ww_win;
  logic [7:0] iw_pre;
  logic [7:0] iw_rld;
  logic [7:0] opt;
  logic [7:0] nopt;
  logic [7:0] iw_cnt;
  logic [7:0] iw_pcnt;
  logic iw_on;
  logic iw_unlock;
  dwdog_pkg::dwdog_evvec_t status;
  dwdog_pkg::dwdog_evvec_t mask;
  dwdog_tick_if ww_tk ();
  dwdog_tick_if ls_tk ();

  dwdog_div #(.DIV(`DWDOG_WW_TICK_CYC)) u_ww_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tk(ww_tk)
  );
  // The independent timebase is a divided tick of the one system clock.
  dwdog_div #(.DIV(`DWDOG_LSRC_DIV)) u_ls_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tk(ls_tk)
  );
  assign ww_tk.clear = 1'b0;
  assign ls_tk.clear = 1'b0;

  wire logic req = cyc_i && stb_i && !ack_o;
  wire logic wr = req && we_i && sel_i;
  wire logic rd = req && !we_i;
  wire logic wr_wwcr = wr && (adr_i == `DWDOG_IDX_WWCR);
  wire logic wr_wwwr = wr && (adr_i == `DWDOG_IDX_WWWR);
  wire logic wr_iwkr = wr && (adr_i == `DWDOG_IDX_IWKR);
  wire logic wr_iwpr = wr && (adr_i == `DWDOG_IDX_IWPR);
  wire logic wr_iwrl = wr && (adr_i == `DWDOG_IDX_IWRLR);
  wire logic wr_opt = wr && (adr_i == `DWDOG_IDX_OPT);
  wire logic wr_nopt = wr && (adr_i == `DWDOG_IDX_NOPT);
  wire logic wr_mask = wr && (adr_i == `DWDOG_IDX_MASK);
  wire logic rd_stat = rd && (adr_i == `DWDOG_IDX_STAT);

  // Option byte is only trusted when its stored complement matches.
  wire logic opt_ok = (opt == ~nopt);
  wire logic ww_hw = opt_ok && opt[`DWDOG_OPT_WW_HW_BIT];
  wire logic iw_hw = opt_ok && opt[`DWDOG_OPT_IW_HW_BIT];

  // Window refresh: counter value above the window means too early.
  wire logic ww_act = ww_ctrl[`DWDOG_WW_ACT_BIT];
  wire logic ww_early = wr_wwcr && ww_act &&
                        (ww_ctrl[6:0] > ww_win[6:0]);
  wire logic ww_expire = ww_act && ww_tk.tick &&
                         (ww_ctrl[6:0] == 7'h40);
  wire logic [7:0] ww_wdat = {ww_act | dat_i[7], dat_i[6:0]};

  wire logic key_en = wr_iwkr && (dat_i == `DWDOG_KEY_ENABLE);
  wire logic key_ref = wr_iwkr && (dat_i == `DWDOG_KEY_REFRESH);
  wire logic key_acc = wr_iwkr && (dat_i == `DWDOG_KEY_ACCESS);
  wire logic [2:0] pr_sel = (iw_pre[2:0] > `DWDOG_PR_MAX) ?
                            `DWDOG_PR_MAX : iw_pre[2:0];
  wire logic [7:0] pr_lim = 8'((`DWDOG_IW_PRE_BASE << pr_sel) - 1);
  wire logic iw_step = iw_on && ls_tk.tick && (iw_pcnt >= pr_lim);
  wire logic iw_expire = iw_step && (iw_cnt == 8'h00);

  wire dwdog_pkg::dwdog_evvec_t ev = {!opt_ok, iw_expire,
                                      ww_expire, ww_early};
  wire logic [7:0] rd_mux =
    (adr_i == `DWDOG_IDX_WWCR) ? ww_ctrl :
    (adr_i == `DWDOG_IDX_WWWR) ? ww_win :
    (adr_i == `DWDOG_IDX_IWPR) ? iw_pre :
    (adr_i == `DWDOG_IDX_IWRLR) ? iw_rld :
    (adr_i == `DWDOG_IDX_OPT) ? opt :
    (adr_i == `DWDOG_IDX_NOPT) ? nopt :
    (adr_i == `DWDOG_IDX_STAT) ? {4'h0, status} :
    (adr_i == `DWDOG_IDX_MASK) ? {4'h0, mask} : 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 8'h00;
    end else begin
      ack_o <= req;
      dat_o <= rd ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opt <= `DWDOG_RST_OPT;
      nopt <= `DWDOG_RST_NOPT;
      mask <= 4'h0;
      ww_win <= `DWDOG_RST_WWWR;
    end else begin
      if (wr_opt) opt <= dat_i;
      if (wr_nopt) nopt <= dat_i;
      if (wr_mask) mask <= dat_i[3:0];
      if (wr_wwwr) ww_win <= {1'b0, dat_i[6:0]};
    end
  end

  // Window watchdog counter; the hardware option forces it active.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ww_ctrl <= `DWDOG_RST_WWCR;
    end else if (wr_wwcr) begin
      ww_ctrl <= ww_wdat;
    end else begin
      if (ww_hw) ww_ctrl[`DWDOG_WW_ACT_BIT] <= 1'b1;
      if (ww_act && ww_tk.tick) ww_ctrl[6:0] <= ww_ctrl[6:0] - 7'h01;
    end
  end

  // The option byte is cleared by reset here, so a valid hardware-enable
  // bit starts the dog whenever it appears, not only just after reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iw_on <= 1'b0;
    end else begin
      if (iw_hw || key_en) iw_on <= 1'b1;
    end
  end

  // Prescaler and reload are writable only after the access key.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iw_unlock <= 1'b0;
      iw_pre <= `DWDOG_RST_IWPR;
      iw_rld <= `DWDOG_RST_IWRLR;
    end else begin
      if (key_acc) iw_unlock <= 1'b1;
      else if (key_ref || key_en) iw_unlock <= 1'b0;
      if (wr_iwpr && iw_unlock) iw_pre <= {5'h00, dat_i[2:0]};
      if (wr_iwrl && iw_unlock) iw_rld <= dat_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iw_cnt <= `DWDOG_RST_IWRLR;
      iw_pcnt <= 8'h00;
    end else if (key_ref || (key_en && !iw_on)) begin
      iw_cnt <= iw_rld;
      iw_pcnt <= 8'h00;
    end else if (iw_on && ls_tk.tick) begin
      if (iw_step) begin
        iw_pcnt <= 8'h00;
        iw_cnt <= iw_cnt - 8'h01;
      end else begin
        iw_pcnt <= iw_pcnt + 8'h01;
      end
    end
  end

  // A set event wins over the read clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= 4'h0;
      irq_o <= 1'b0;
      wdog_reset_o <= 1'b0;
    end else begin
      status <= (rd_stat ? 4'h0 : status) | ev;
      irq_o <= |(((rd_stat ? 4'h0 : status) | ev) & mask);
      wdog_reset_o <= ww_early || ww_expire || iw_expire;
    end
  end
endmodule
`default_nettype wire

// [dwdog_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module dwdog_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [7:0] dat_o,
  input wire logic ack_o,
  input wire logic wdog_reset_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd_ww;
  logic ww_on;
  // The flag drops on a trip too, in case the trip resets the block inside.
  always_ff @(posedge clk_i) begin
    rd_ww <= !rst_i && cyc_i && stb_i && !we_i && !ack_o
      && adr_i == 16'h50D1;
    if (rst_i || wdog_reset_o)
      ww_on <= 1'b0;
    else if (ack_o && rd_ww && dat_o[7])
      ww_on <= 1'b1;
  end
  chk_ack_once: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  chk_dat_idle: assert property (!ack_o |-> dat_o == 8'h00)
    else $error("read data outside ack");
  chk_hole_zero: assert property (ack_o && $past(!we_i
    && adr_i == 16'h50E3) |-> dat_o == 8'h00)
    else $error("unmapped read not zero");
  chk_trip_pulse: assert property (wdog_reset_o |=> !wdog_reset_o)
    else $error("reset request longer than one cycle");
  chk_rst_quiet: assert property ($fell(rst_i) |->
    !(ack_o || irq_o || wdog_reset_o))
    else $error("outputs active after reset");
  chk_act_sticky: assert property (ack_o && rd_ww && ww_on |-> dat_o[7])
    else $error("window dog stopped by software");
endmodule
bind dwdog_top dwdog_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_o(dat_o), .ack_o(ack_o), .wdog_reset_o(wdog_reset_o),
  .irq_o(irq_o));
`default_nettype wire

// [dwdog_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module dwdog_top_tb;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, sel_i, ack_o, wdog_reset_o, irq_o;
  logic [15:0] adr_i;
  logic [7:0] dat_i, dat_o, d;
  int error_cnt, checks_done, cyc_cnt;
  dwdog_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i),
    .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
    .wdog_reset_o(wdog_reset_o), .irq_o(irq_o));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task wrap_up;
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    sel_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= v;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    d = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(d & m, e);
  endtask
  // Samples the pulse at each edge, so a one-cycle request is never missed.
  task trip(input int n);
    for (int i = 0; i < n && wdog_reset_o !== 1'b1; i++) @(posedge clk_i);
    chk({7'h00, wdog_reset_o}, 8'h01);
  endtask
  task reset;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 90000) begin
      error_cnt++;
      wrap_up;
    end
  end
  initial begin
    {rst_i, cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} = 29'h10000000;
    error_cnt = 0;
    checks_done = 0;
    cyc_cnt = 0;
    reset;
    rd(16'h50D1, 8'hFF, 8'h7F);
    rd(16'h50D2, 8'hFF, 8'h7F);
    rd(16'h50E1, 8'hFF, 8'h00);
    rd(16'h50E2, 8'hFF, 8'hFF);
    rd(16'h50E3, 8'hFF, 8'h00);
    bus(1'b1, 16'h50E2, 8'h10);
    rd(16'h50E2, 8'hFF, 8'hFF);
    bus(1'b1, 16'h50E0, 8'h55);
    bus(1'b1, 16'h50E2, 8'h04);
    rd(16'h50E2, 8'hFF, 8'h04);
    bus(1'b1, 16'h50E7, 8'h04);
    bus(1'b1, 16'h50E0, 8'hCC);
    repeat (5) begin
      repeat (2000) @(posedge clk_i);
      bus(1'b1, 16'h50E0, 8'hAA);
    end
    rd(16'h50E6, 8'h04, 8'h00);
    trip(17000);
    repeat (2) @(posedge clk_i);
    chk({7'h00, irq_o}, 8'h01);
    rd(16'h50E6, 8'h04, 8'h04);
    repeat (2) @(posedge clk_i);
    chk({7'h00, irq_o}, 8'h00);
    reset;
    bus(1'b1, 16'h50E7, 8'h02);
    bus(1'b1, 16'h50D1, 8'hC0);
    rd(16'h50D1, 8'hFF, 8'hC0);
    bus(1'b1, 16'h50D1, 8'h41);
    rd(16'h50D1, 8'hFF, 8'hC1);
    trip(26000);
    rd(16'h50E6, 8'h02, 8'h02);
    reset;
    bus(1'b1, 16'h50D2, 8'h50);
    bus(1'b1, 16'h50D1, 8'hFF);
    bus(1'b1, 16'h50D1, 8'hFF);
    trip(10);
    rd(16'h50E6, 8'h01, 8'h01);
    reset;
    bus(1'b1, 16'h50E0, 8'h55);
    bus(1'b1, 16'h50E2, 8'h04);
    bus(1'b1, 16'h50E0, 8'hAA);
    bus(1'b1, 16'h50E4, 8'h04);
    rd(16'h50E6, 8'h08, 8'h08);
    bus(1'b1, 16'h50E5, 8'hFB);
    rd(16'h50E6, 8'h08, 8'h08);
    rd(16'h50E6, 8'h08, 8'h00);
    trip(17000);
    wrap_up;
  end
endmodule
`default_nettype wire
